// File: sgsel_pkg.sv
package sgsel_pkg;

	// ==========================================================
	// Group geometry
	localparam int SGSEL_GROUPS = 8;
	localparam int SGSEL_IDX_W = 3;
	localparam int SGSEL_SEL_W = 4;

	// ==========================================================
	// Register offsets (byte addresses)
	localparam logic [7:0] SGSEL_OFF_CTRL = 8'h00;
	localparam logic [7:0] SGSEL_OFF_FORCE = 8'h04;
	localparam logic [7:0] SGSEL_OFF_REMOTE = 8'h08;
	localparam logic [7:0] SGSEL_OFF_STATUS = 8'h0c;
	localparam logic [7:0] SGSEL_OFF_FAIL_CLR = 8'h10;
	localparam logic [7:0] SGSEL_OFF_LEVELS = 8'h14;

	// ==========================================================
	// Field positions
	localparam int SGSEL_CTRL_ENA_BIT = 0;
	localparam int SGSEL_CTRL_USED_LSB = 4;
	localparam int SGSEL_STAT_ACT_LSB = 0;
	localparam int SGSEL_STAT_FAIL_LSB = 8;
	localparam int SGSEL_STAT_MODE_LSB = 12;
	localparam int SGSEL_LVL_EN_LSB = 8;
	localparam int SGSEL_FAIL_NCFG = 0;
	localparam int SGSEL_FAIL_FORCE = 1;
	localparam int SGSEL_FAIL_PRIO = 2;
	localparam int SGSEL_FAIL_W = 3;

	// ==========================================================
	// Reset values and codes
	localparam logic [2:0] SGSEL_USED_RST = 3'h0;
	localparam logic [2:0] SGSEL_ACT_RST = 3'h0;
	localparam logic [3:0] SGSEL_SEL_NONE = 4'h0;
	localparam logic [3:0] SGSEL_NUM_ONE = 4'h1;
	localparam logic [7:0] SGSEL_HOT_RST = 8'h01;

	// ==========================================================
	// Types
	typedef enum logic [1:0] {
		SGSEL_MODE_IDLE = 2'b00,
		SGSEL_MODE_AUTO = 2'b01,
		SGSEL_MODE_FORCE = 2'b10
	} sgsel_mode_e;

	typedef struct packed {
		logic sel;
		logic enable;
		logic write;
		logic [7:0] addr;
		logic [31:0] wdata;
	} sgsel_apb_s;

endpackage

// File: sgsel_req_model.sv
module sgsel_req_model
	import sgsel_pkg::*;
(
	// Clock
	input wire logic i_clk,
	// Request pins toward the selector
	output logic [SGSEL_GROUPS-1:0] o_req
);
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================================
	// Level and pulse sources
	logic [SGSEL_GROUPS-1:0] lvl = '0;
	logic [SGSEL_GROUPS-1:0] pls = '0;

	assign o_req = lvl | pls;

	task automatic set_levels(input logic [SGSEL_GROUPS-1:0] v);
		@(posedge i_clk);
		lvl <= v;
	endtask

	// Pulse lasts three clocks so the two sync flops surely see it
	task automatic pulse(input int g);
		@(posedge i_clk);
		pls[g-1] <= 1'b1;
		repeat (3) @(posedge i_clk);
		pls <= '0;
	endtask
endmodule

// File: sgsel_req_sync.sv
module sgsel_req_sync
	import sgsel_pkg::*;
#(
	parameter int N = SGSEL_GROUPS
)(
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rstn,
	// Raw request pins
	input wire logic [N-1:0] i_req,
	// Synchronised level and rising-edge pulse
	output logic [N-1:0] o_level,
	output logic [N-1:0] o_rise
);

	// ==========================================================
	// Per-input two-stage synchroniser and edge detector
	logic [N-1:0] meta;
	logic [N-1:0] sync;
	logic [N-1:0] prev;

	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_req
			always_ff @(posedge i_mclk) begin
				if (!i_rstn) begin
					meta[g] <= 1'b0;
					sync[g] <= 1'b0;
					prev[g] <= 1'b0;
				end else begin
					meta[g] <= i_req[g];
					sync[g] <= meta[g];
					prev[g] <= sync[g];
				end
			end

			assign o_level[g] = sync[g];
			assign o_rise[g] = sync[g] & ~prev[g];

			a_rise_single: assert property (@(posedge i_mclk)
				disable iff (!i_rstn) o_rise[g] |=> !o_rise[g])
				else $error("request edge pulse lasted two cycles");
		end
	endgenerate

endmodule

// File: sgsel_top.sv
// Functional notes
// - Up to eight groups; exactly one group active at all times.
// - After reset only group one enabled and active; requests ignored.
// - With more groups enabled, requests decide the active group.
// - Force override enabled: automatic requests ignored, only forced group used.
// - Requests work both as short pulses and as held levels.
// - Several requests together: highest-priority requested group wins.
// - Priority by number: group one highest, group eight lowest.
// - Two held levels keep the higher-priority group active.
// - Pulse-selected group stays latched until another group is requested.
// - Force override cleared with levels present: levels take control at once.
// - Read-only active group indication, group one after reset.
// - Forced selection is none or one to eight, defaults none, acts as pulse.
// - Force override enable resets disabled and holds until cleared.
// - Used group count enables group one up to groups one to eight.
// - Remote change refused while a higher-priority group is held by level.
// - Held level blocks every lower-priority request.
// - Failure flags: unconfigured target, failed force, lower-priority refusal.
module sgsel_top
	import sgsel_pkg::*;
(
	// Clock and reset
	input wire logic I_MCLK,
	input wire logic I_RSTN,
	// APB slave
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [7:0] I_PADDR,
	input wire logic [31:0] I_PWDATA,
	output logic [31:0] O_PRDATA,
	output logic O_PREADY,
	output logic O_PSLVERR,
	// Group request pins
	input wire logic [SGSEL_GROUPS-1:0] I_GROUP_REQ,
	// Active group and status
	output logic [SGSEL_SEL_W-1:0] O_ACTIVE_GROUP,
	output logic [SGSEL_GROUPS-1:0] O_ACTIVE_ONEHOT,
	output logic O_FORCE_ACTIVE,
	// Failure events
	output logic O_FAIL_NOT_CONFIGURED,
	output logic O_FAIL_FORCE,
	output logic O_FAIL_LOWER_PRIORITY
);

	// ==========================================================
	// Helper functions
	function automatic logic [SGSEL_GROUPS-1:0] sel_mask(
		input logic [SGSEL_SEL_W-1:0] sel);
		logic [SGSEL_GROUPS-1:0] m;
		m = '0;
		for (int i = 0; i < SGSEL_GROUPS; i++) begin
			if (sel == SGSEL_SEL_W'(i + 1)) begin
				m[i] = 1'b1;
			end
		end
		return m;
	endfunction

	function automatic logic [SGSEL_IDX_W-1:0] first_set(
		input logic [SGSEL_GROUPS-1:0] v);
		logic [SGSEL_IDX_W-1:0] idx;
		idx = '0;
		for (int i = SGSEL_GROUPS - 1; i >= 0; i--) begin
			if (v[i]) begin
				idx = SGSEL_IDX_W'(i);
			end
		end
		return idx;
	endfunction

	function automatic logic [SGSEL_GROUPS-1:0] below_mask(
		input logic [SGSEL_IDX_W-1:0] idx);
		logic [SGSEL_GROUPS-1:0] m;
		m = '0;
		for (int i = 0; i < SGSEL_GROUPS; i++) begin
			m[i] = (i > int'(idx));
		end
		return m;
	endfunction

	// ==========================================================
	// State
	logic force_en;
	logic [SGSEL_IDX_W-1:0] used;
	logic [SGSEL_SEL_W-1:0] force_sel;
	logic [SGSEL_SEL_W-1:0] remote_sel;
	logic [SGSEL_IDX_W-1:0] active;
	logic [SGSEL_SEL_W-1:0] act_num;
	logic [SGSEL_GROUPS-1:0] act_hot;
	logic [SGSEL_FAIL_W-1:0] fail;
	logic [SGSEL_FAIL_W-1:0] fail_evt;
	logic [31:0] prdata;
	logic pslverr;

	// ==========================================================
	// Bus decode
	sgsel_apb_s apb;
	wire logic setup;
	wire logic wr;
	wire logic hit_ctrl;
	wire logic hit_force;
	wire logic hit_remote;
	wire logic hit_status;
	wire logic hit_clr;
	wire logic hit_lvl;
	wire logic hit_any;

	assign apb = '{sel: I_PSEL, enable: I_PENABLE, write: I_PWRITE,
		addr: I_PADDR, wdata: I_PWDATA};
	assign setup = apb.sel & ~apb.enable;
	assign wr = apb.sel & apb.enable & apb.write;
	assign hit_ctrl = apb.addr == SGSEL_OFF_CTRL;
	assign hit_force = apb.addr == SGSEL_OFF_FORCE;
	assign hit_remote = apb.addr == SGSEL_OFF_REMOTE;
	assign hit_status = apb.addr == SGSEL_OFF_STATUS;
	assign hit_clr = apb.addr == SGSEL_OFF_FAIL_CLR;
	assign hit_lvl = apb.addr == SGSEL_OFF_LEVELS;
	assign hit_any = hit_ctrl | hit_force | hit_remote | hit_status |
		hit_clr | hit_lvl;

	wire logic wr_ctrl;
	wire logic wr_force;
	wire logic wr_remote;
	wire logic wr_clr;
	wire logic [SGSEL_SEL_W-1:0] wsel;

	assign wr_ctrl = wr & hit_ctrl;
	assign wr_force = wr & hit_force;
	assign wr_remote = wr & hit_remote;
	assign wr_clr = wr & hit_clr;
	assign wsel = apb.wdata[SGSEL_SEL_W-1:0];

	// ==========================================================
	// Request inputs
	logic [SGSEL_GROUPS-1:0] lvl_raw;
	logic [SGSEL_GROUPS-1:0] rise_raw;

	sgsel_req_sync #(
		.N(SGSEL_GROUPS)
	) u_sync (
		.i_mclk(I_MCLK),
		.i_rstn(I_RSTN),
		.i_req(I_GROUP_REQ),
		.o_level(lvl_raw),
		.o_rise(rise_raw)
	);

	// ==========================================================
	// Enabled range and mode
	wire logic [SGSEL_GROUPS-1:0] en;
	sgsel_mode_e mode;

	genvar g;
	generate
		for (g = 0; g < SGSEL_GROUPS; g++) begin : g_en
			assign en[g] = g <= int'(used);
		end
	endgenerate

	assign mode = force_en ? SGSEL_MODE_FORCE :
		(used == SGSEL_USED_RST) ? SGSEL_MODE_IDLE :
		SGSEL_MODE_AUTO;

	// ==========================================================
	// Priority resolution
	wire logic [SGSEL_GROUPS-1:0] lvl;
	wire logic [SGSEL_GROUPS-1:0] rise;
	wire logic [SGSEL_GROUPS-1:0] blk;
	wire logic [SGSEL_GROUPS-1:0] rmt_mask;
	wire logic [SGSEL_GROUPS-1:0] rmt_ok;
	wire logic [SGSEL_GROUPS-1:0] cand;
	wire logic [SGSEL_IDX_W-1:0] win;
	wire logic rmt_req;
	wire logic rmt_blocked;

	assign lvl = lvl_raw & en;
	assign rise = rise_raw & en;
	assign blk = below_mask(first_set(lvl)) & {SGSEL_GROUPS{|lvl}};
	assign rmt_req = wr_remote & (mode == SGSEL_MODE_AUTO);
	assign rmt_mask = sel_mask(wsel) & en & {SGSEL_GROUPS{rmt_req}};
	assign rmt_ok = rmt_mask & ~blk;
	assign rmt_blocked = |(rmt_mask & blk);
	assign cand = lvl | rise | rmt_ok;
	assign win = first_set(cand);

	// ==========================================================
	// Force path
	wire logic [SGSEL_GROUPS-1:0] force_mask;
	wire logic [SGSEL_IDX_W-1:0] force_idx;
	wire logic force_ok;

	assign force_mask = sel_mask(wsel) & en;
	assign force_idx = first_set(force_mask);
	assign force_ok = wr_force & force_en & (|force_mask);

	// ==========================================================
	// Failure detection
	wire logic [SGSEL_FAIL_W-1:0] fail_now;
	wire logic [SGSEL_FAIL_W-1:0] fail_clr;
	wire logic rmt_ncfg;

	assign rmt_ncfg = rmt_req & (wsel != SGSEL_SEL_NONE) &
		~(|(sel_mask(wsel) & en));
	assign fail_now[SGSEL_FAIL_NCFG] = (|(rise_raw & ~en)) | rmt_ncfg;
	assign fail_now[SGSEL_FAIL_FORCE] = wr_force &
		(wsel != SGSEL_SEL_NONE) & ~force_ok;
	assign fail_now[SGSEL_FAIL_PRIO] = (mode == SGSEL_MODE_AUTO) &
		((|(rise & blk)) | rmt_blocked);
	assign fail_clr = wr_clr ? apb.wdata[SGSEL_FAIL_W-1:0] : '0;

	// ==========================================================
	// Next active group
	logic [SGSEL_IDX_W-1:0] next_active;

	always_comb begin
		next_active = active;
		case (mode)
			SGSEL_MODE_IDLE: begin
				next_active = SGSEL_ACT_RST;
			end
			SGSEL_MODE_FORCE: begin
				if (force_ok) begin
					next_active = force_idx;
				end
			end
			SGSEL_MODE_AUTO: begin
				if (|cand) begin
					next_active = win;
				end
			end
			default: begin
				next_active = SGSEL_ACT_RST;
			end
		endcase
	end

	// ==========================================================
	// Read data
	wire logic [31:0] ctrl_rd;
	wire logic [31:0] status_rd;
	wire logic [31:0] lvl_rd;
	wire logic [31:0] rd_data;

	assign ctrl_rd = (32'(force_en) << SGSEL_CTRL_ENA_BIT) |
		(32'(used) << SGSEL_CTRL_USED_LSB);
	assign status_rd = (32'(act_num) << SGSEL_STAT_ACT_LSB) |
		(32'(fail) << SGSEL_STAT_FAIL_LSB) |
		(32'(mode) << SGSEL_STAT_MODE_LSB);
	assign lvl_rd = 32'(lvl_raw) | (32'(en) << SGSEL_LVL_EN_LSB);
	assign rd_data = hit_ctrl ? ctrl_rd :
		hit_force ? 32'(force_sel) :
		hit_remote ? 32'(remote_sel) :
		hit_status ? status_rd :
		hit_lvl ? lvl_rd : 32'h0000_0000;

	// ==========================================================
	// Bus registers
	always_ff @(posedge I_MCLK) begin
		if (!I_RSTN) begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (setup) begin
			prdata <= rd_data;
			pslverr <= ~hit_any;
		end
	end

	// ==========================================================
	// Settings registers
	always_ff @(posedge I_MCLK) begin
		if (!I_RSTN) begin
			force_en <= 1'b0;
			used <= SGSEL_USED_RST;
			force_sel <= SGSEL_SEL_NONE;
			remote_sel <= SGSEL_SEL_NONE;
		end else begin
			if (wr_ctrl) begin
				force_en <= apb.wdata[SGSEL_CTRL_ENA_BIT];
				used <= apb.wdata[SGSEL_CTRL_USED_LSB +: SGSEL_IDX_W];
			end
			if (wr_force) begin
				force_sel <= wsel;
			end
			if (wr_remote) begin
				remote_sel <= wsel;
			end
		end
	end

	// ==========================================================
	// Active group and failure flags
	always_ff @(posedge I_MCLK) begin
		if (!I_RSTN) begin
			active <= SGSEL_ACT_RST;
			act_num <= SGSEL_NUM_ONE;
			act_hot <= SGSEL_HOT_RST;
			fail <= '0;
			fail_evt <= '0;
		end else begin
			active <= next_active;
			act_num <= {1'b0, next_active} + SGSEL_NUM_ONE;
			act_hot <= SGSEL_GROUPS'(SGSEL_HOT_RST << next_active);
			fail <= (fail & ~fail_clr) | fail_now;
			fail_evt <= fail_now;
		end
	end

	// ==========================================================
	// Outputs
	assign O_PRDATA = prdata;
	assign O_PREADY = 1'b1;
	assign O_PSLVERR = pslverr;
	assign O_ACTIVE_GROUP = act_num;
	assign O_ACTIVE_ONEHOT = act_hot;
	assign O_FORCE_ACTIVE = force_en;
	assign O_FAIL_NOT_CONFIGURED = fail_evt[SGSEL_FAIL_NCFG];
	assign O_FAIL_FORCE = fail_evt[SGSEL_FAIL_FORCE];
	assign O_FAIL_LOWER_PRIORITY = fail_evt[SGSEL_FAIL_PRIO];

	// ==========================================================
	// Assertions
	default clocking cb @(posedge I_MCLK);
	endclocking
	default disable iff (!I_RSTN);

	a_one_active: assert property (
		$onehot(O_ACTIVE_ONEHOT) &&
		O_ACTIVE_GROUP == {1'b0, active} + SGSEL_NUM_ONE)
		else $error("active group not exactly one");

	a_idle_group_one: assert property (
		(mode == SGSEL_MODE_IDLE) |=> O_ACTIVE_GROUP == SGSEL_NUM_ONE)
		else $error("idle selector left group one");

	a_force_blocks: assert property (
		force_en && !wr_force |=> $stable(active))
		else $error("automatic request moved forced group");

	a_force_apply: assert property (
		force_ok |=> active == $past(force_idx) ##1 $stable(active))
		else $error("forced group not applied");

	a_priority_win: assert property (
		(mode == SGSEL_MODE_AUTO) && (|cand) |=>
		active == $past(win))
		else $error("wrong group won priority");

	a_level_one_holds: assert property (
		(mode == SGSEL_MODE_AUTO) && lvl[0] ##1
		(mode == SGSEL_MODE_AUTO) && lvl[0] |=> active == SGSEL_ACT_RST)
		else $error("group one level did not hold");

	a_pulse_latched: assert property (
		(mode == SGSEL_MODE_AUTO) && !(|cand) |=> $stable(active))
		else $error("latched group changed with no request");

	a_release_levels: assert property (
		$fell(force_en) && (used != SGSEL_USED_RST) && (|lvl) |=>
		active == $past(win))
		else $error("levels did not regain control");

	a_remote_refused: assert property (
		rmt_blocked |=> fail[SGSEL_FAIL_PRIO] ##1 fail[SGSEL_FAIL_PRIO] ||
		$past(wr_clr))
		else $error("blocked remote change not flagged");

	a_force_fail: assert property (
		wr_force && !force_en && wsel != SGSEL_SEL_NONE && !(|cand) |=>
		O_FAIL_FORCE && fail[SGSEL_FAIL_FORCE] && $stable(active))
		else $error("force without enable not flagged");

	a_disabled_ignored: assert property (
		(mode == SGSEL_MODE_AUTO) && !(|cand) && (|(rise_raw & ~en)) |=>
		$stable(active) && O_FAIL_NOT_CONFIGURED)
		else $error("unconfigured request acted");

	c_force_used: cover property (force_ok ##1 !force_en);
	c_remote_taken: cover property (|rmt_ok);
	c_prio_refused: cover property (fail_now[SGSEL_FAIL_PRIO]);
	c_level_switch: cover property ($changed(active) && (|lvl));

endmodule

// File: testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import sgsel_pkg::*;

	// ==========================================================
	// Signals
	logic mclk = 1'b0;
	logic rstn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [SGSEL_GROUPS-1:0] group_req;
	logic [SGSEL_SEL_W-1:0] act;
	logic [SGSEL_GROUPS-1:0] onehot;
	logic force_act;
	logic f_nc;
	logic f_ff;
	logic f_lp;
	int n_nc = 0;
	int n_ff = 0;
	int n_lp = 0;
	int err_count = 0;
	int checks = 0;
	logic [31:0] rd;
	logic er;
	logic [7:0] lv;
	logic [3:0] exp_g;
	int g;

	always #2 mclk = ~mclk;

	sgsel_req_model model (.i_clk(mclk), .o_req(group_req));

	sgsel_top DUT (
		.I_MCLK(mclk), .I_RSTN(rstn), .I_PSEL(psel), .I_PENABLE(penable),
		.I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
		.O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
		.I_GROUP_REQ(group_req), .O_ACTIVE_GROUP(act),
		.O_ACTIVE_ONEHOT(onehot), .O_FORCE_ACTIVE(force_act),
		.O_FAIL_NOT_CONFIGURED(f_nc), .O_FAIL_FORCE(f_ff),
		.O_FAIL_LOWER_PRIORITY(f_lp)
	);

	// ==========================================================
	// Failure pulse counters
	always @(posedge mclk) begin
		if (rstn) begin
			n_nc <= n_nc + int'(f_nc);
			n_ff <= n_ff + int'(f_ff);
			n_lp <= n_lp + int'(f_lp);
		end
	end

	// ==========================================================
	// Checking helpers
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic chk_act(input logic [3:0] g);
		chk({28'h0, act}, {28'h0, g});
		chk({24'h0, onehot}, 32'h1 << (g - 1));
	endtask

	function automatic logic [3:0] prio(input logic [7:0] v,
		input logic [2:0] used);
		prio = 4'h0;
		for (int i = 7; i >= 0; i--) begin
			if (v[i] && i <= used) begin
				prio = 4'(i + 1);
			end
		end
	endfunction

	// ==========================================================
	// APB master
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, rd, er);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0, rd, er);
		chk(rd, exp);
	endtask

	task automatic settle();
		repeat (6) @(posedge mclk);
	endtask

	task automatic close_out();
		$display("checks %0d errors %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// ==========================================================
	// Watchdog
	initial begin
		#100000;
		err_count++;
		close_out();
	end

	// ==========================================================
	// Main sequence
	initial begin
		void'($urandom(32'h02c7ae21));
		repeat (4) @(posedge mclk);
		rstn <= 1'b1;
		@(posedge mclk);
		chk_act(4'h1);
		chk({31'h0, force_act}, 32'h0);
		rd_chk(SGSEL_OFF_CTRL, 32'h0);
		rd_chk(SGSEL_OFF_STATUS, 32'h1);
		model.set_levels(8'h08);
		settle();
		chk_act(4'h1);
		rd_chk(SGSEL_OFF_STATUS, 32'h0101);
		chk(n_nc, 32'h1);
		model.set_levels(8'h00);
		wr(SGSEL_OFF_FAIL_CLR, 32'h7);
		rd_chk(SGSEL_OFF_STATUS, 32'h0001);
		wr(SGSEL_OFF_CTRL, 32'h70);
		rd_chk(SGSEL_OFF_LEVELS, 32'hff00);
		model.pulse(3);
		settle();
		chk_act(4'h3);
		model.set_levels(8'h0a);
		settle();
		chk_act(4'h2);
		wr(SGSEL_OFF_REMOTE, 32'h5);
		settle();
		chk_act(4'h2);
		rd_chk(SGSEL_OFF_STATUS, 32'h1402);
		chk(n_lp, 32'h2);
		wr(SGSEL_OFF_FAIL_CLR, 32'h7);
		wr(SGSEL_OFF_CTRL, 32'h71);
		wr(SGSEL_OFF_FORCE, 32'h6);
		settle();
		chk({31'h0, force_act}, 32'h1);
		chk_act(4'h6);
		rd_chk(SGSEL_OFF_STATUS, 32'h2006);
		wr(SGSEL_OFF_CTRL, 32'h70);
		settle();
		chk_act(4'h2);
		model.set_levels(8'h00);
		wr(SGSEL_OFF_CTRL, 32'h71);
		wr(SGSEL_OFF_FORCE, 32'h7);
		wr(SGSEL_OFF_CTRL, 32'h70);
		settle();
		chk_act(4'h7);
		wr(SGSEL_OFF_FORCE, 32'h3);
		settle();
		chk_act(4'h7);
		rd_chk(SGSEL_OFF_STATUS, 32'h1207);
		chk(n_ff, 32'h1);
		wr(SGSEL_OFF_FAIL_CLR, 32'h7);
		wr(SGSEL_OFF_CTRL, 32'h10);
		model.pulse(5);
		settle();
		chk_act(4'h7);
		rd_chk(SGSEL_OFF_STATUS, 32'h1107);
		chk(n_nc, 32'h2);
		rd_chk(SGSEL_OFF_LEVELS, 32'h0300);
		wr(SGSEL_OFF_STATUS, 32'hffff);
		wr(SGSEL_OFF_FAIL_CLR, 32'h7);
		rd_chk(SGSEL_OFF_STATUS, 32'h1007);
		apb(1'b0, 8'h20, 32'h0, rd, er);
		chk({31'h0, er}, 32'h1);
		chk(rd, 32'h0);
		wr(SGSEL_OFF_CTRL, 32'h70);
		exp_g = 4'h7;
		for (int k = 0; k < 12; k++) begin
			lv = 8'($urandom);
			model.set_levels(lv);
			settle();
			if (lv != 8'h00) begin
				exp_g = prio(lv, 3'h7);
			end
			chk_act(exp_g);
			model.set_levels(8'h00);
			settle();
			g = 1 + int'($urandom % 8);
			model.pulse(g);
			settle();
			exp_g = 4'(g);
			chk_act(exp_g);
		end
		wr(SGSEL_OFF_CTRL, 32'h71);
		wr(SGSEL_OFF_FORCE, 32'h4);
		settle();
		chk_act(4'h4);
		@(posedge mclk);
		rstn <= 1'b0;
		repeat (4) @(posedge mclk);
		rstn <= 1'b1;
		@(posedge mclk);
		chk_act(4'h1);
		chk({31'h0, force_act}, 32'h0);
		rd_chk(SGSEL_OFF_CTRL, 32'h0);
		close_out();
	end
endmodule
